/* design/sync_card_pkg.sv */
// Package: constants and carriers for the four-line sync line card
package sync_card_pkg;
	localparam int LINES = 4;
	localparam int CHAR_W = 8;
	// Line control register bit positions
	localparam int LCR_RX_DATA_BIT = 7;
	localparam int LCR_MAINT_CLK_BIT = 8;
	localparam int LCR_TX_DIS_BIT = 9;
	localparam int LCR_SYNC_SEL_BIT = 10;
	localparam int LCR_MODE_LO_BIT = 11;
	localparam int LCR_MODE_HI_BIT = 12;
	localparam int LCR_RX_EN_BIT = 13;
	localparam int LCR_MAINT_DATA_BIT = 14;
	// Maintenance modes
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_INT_MAINT = 2'h1;
	localparam logic [1:0] MODE_EXT_MAINT = 2'h2;
	localparam logic [1:0] MODE_BAUD_MAINT = 2'h3;
	// Pulse timing
	localparam int CLK_MHZ = 20;
	localparam int PULSE_NS = 300;
	localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [2:0] PULSE_CYC_W = 3'(PULSE_CYC);
	// Internal baud: divide of clk to baud (default 9600, half-period count)
	localparam int BAUD_DEFAULT = 9600;
	localparam logic [3:0] RST_SETUP = 4'h0;
	// Maintenance register fields
	typedef struct packed {
		logic tx_disable;
		logic [1:0] mode;
		logic maint_data;
	} setup_t;
	// Four flags presented for the scanned line
	typedef struct packed {
		logic tx_idle;
		logic tx_ready;
		logic sync_match;
		logic rx_flag;
	} scan_flags_t;
endpackage

/* design/sync_line_card_control.sv */
// Control logic for a four-line synchronous line card
//
// What this block does
// RL1 - Top scan bits pick card, low pick line
// RL2 - Bit 10 selects sync switch A or B
// RL3 - Strobe loads sync char into line holding
// RL4 - Two flags shown for scanned line direction
// RL5 - Mode 01 routes line receive data to bit7
// RL6 - Commands load resync or force-mark flip-flops
// RL7 - Accept pulse clears flag; load pulse loads holding
// RL8 - Strobe loads receiver enable into search-sync
// RL9 - Line clocks from modem, maintenance or baud
// RL10 - Mode bit0 blocks modem; gate maint clocks
// RL11 - Terminal timing follows baud, bit8 in 01
// RL12 - Half duplex: clear-to-send blocks receive clock
// RL13 - Strobe captures bits 9,11,12,14 into setup
// RL14 - Single sync off: flag on sync match
// RL15 - Single sync on: flag on char ready
// RL16 - Software sets enable with strobe to hunt
// RL17 - Receiver syncs rising, shifts falling edge
// RL18 - Resync pulse sets first flop, clears status
// RL19 - Same rising sets second; hunt held negated
// RL20 - First clears falling; second toggles rising
// RL21 - Match drops on falling; resync rising
// RL22 - Force-mark holds transmit output at mark
// RL23 - Initialization clears card control state
`timescale 1ns/1ps
`default_nettype none
module sync_line_card_control
	import sync_card_pkg::*;
#(
	parameter logic [1:0] CARD_ID = 2'h0,
	parameter int BAUD_DIV = 1042
)
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [4:0] master_scan_i,
	input wire logic [3:0] secondary_select_i,
	input wire logic [15:0] line_control_register_i,
	input wire logic ctrl_strobe_i,
	input wire logic resync_cmd_i,
	input wire logic force_mark_cmd_i,
	input wire logic force_mark_val_i,
	input wire logic accept_cmd_i,
	input wire logic load_cmd_i,
	input wire logic [CHAR_W-1:0] sync_sw_a_i,
	input wire logic [CHAR_W-1:0] sync_sw_b_i,
	input wire logic single_sync_sw_i,
	input wire logic [LINES-1:0] half_duplex_sw_i,
	input wire logic [LINES-1:0] modem_tx_clk_i,
	input wire logic [LINES-1:0] modem_rx_clk_i,
	input wire logic [LINES-1:0] rx_data_i,
	input wire logic [LINES-1:0] tx_data_raw_i,
	input wire logic [LINES-1:0] clear_to_send_i,
	input wire logic [LINES-1:0] tx_idle_i,
	input wire logic [LINES-1:0] tx_ready_i,
	input wire logic [LINES-1:0] sync_match_flag_i,
	input wire logic [LINES-1:0] char_ready_i,
	input wire logic rx_line_clk_i,
	output logic [3:0] scan_flags_o,
	output logic rx_bit_window_o,
	output logic [CHAR_W-1:0] sync_char_o,
	output logic [LINES-1:0] sync_load_o,
	output logic [LINES-1:0] receive_accept_pulse_o,
	output logic [LINES-1:0] holding_load_pulse_o,
	output logic [LINES-1:0] hunt_req_o,
	output logic [LINES-1:0] status_clear_o,
	output logic [LINES-1:0] tx_line_clk_o,
	output logic [LINES-1:0] rx_clk_gated_o,
	output logic [LINES-1:0] scte_o,
	output logic [LINES-1:0] tx_data_o,
	output logic [3:0] setup_o
);
	// Card and line decode
	logic scan_card_hit;
	logic sel_card_hit;
	logic [1:0] scan_line;
	logic [1:0] sel_line;
	assign scan_card_hit = (master_scan_i[4:3] == CARD_ID); // RL1
	assign scan_line = master_scan_i[2:1]; // RL1
	assign sel_card_hit = (secondary_select_i[3:2] == CARD_ID); // RL1
	assign sel_line = secondary_select_i[1:0]; // RL1

	// Modem, status and receive data inputs pass two flops before any logic
	logic [LINES-1:0] mtx_s1_r, mtx_s2_r, mrx_s1_r, mrx_s2_r, rxd_s1_r, rxd_s2_r;
	logic [LINES-1:0] cts_s1_r, cts_s2_r, cr_s1_r, cr_s2_r, sm_s1_r, sm_s2_r;
	logic [LINES-1:0] ti_s1_r, ti_s2_r, tr_s1_r, tr_s2_r;
	always_ff @(posedge clk_i)
	begin
		mtx_s1_r <= modem_tx_clk_i;
		mtx_s2_r <= mtx_s1_r;
		mrx_s1_r <= modem_rx_clk_i;
		mrx_s2_r <= mrx_s1_r;
		rxd_s1_r <= rx_data_i;
		rxd_s2_r <= rxd_s1_r;
		cts_s1_r <= clear_to_send_i;
		cts_s2_r <= cts_s1_r;
		cr_s1_r <= char_ready_i;
		cr_s2_r <= cr_s1_r;
		sm_s1_r <= sync_match_flag_i;
		sm_s2_r <= sm_s1_r;
		ti_s1_r <= tx_idle_i;
		ti_s2_r <= ti_s1_r;
		tr_s1_r <= tx_ready_i;
		tr_s2_r <= tr_s1_r;
	end

	// Maintenance register, whole card, captured on strobe
	setup_t setup_r;
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			setup_r <= setup_t'(RST_SETUP); // RL23
		else if (ctrl_strobe_i && sel_card_hit)
		begin
			setup_r.tx_disable <= line_control_register_i[LCR_TX_DIS_BIT]; // RL13
			setup_r.mode <= {line_control_register_i[LCR_MODE_HI_BIT],
				line_control_register_i[LCR_MODE_LO_BIT]}; // RL13
			setup_r.maint_data <= line_control_register_i[LCR_MAINT_DATA_BIT]; // RL13
		end
	end
	assign setup_o = setup_r;

	// Sync character choice and per-line holding load
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			sync_char_o <= '0;
			sync_load_o <= '0;
		end
		else
		begin
			sync_char_o <= line_control_register_i[LCR_SYNC_SEL_BIT] ? sync_sw_b_i : sync_sw_a_i; // RL2
			sync_load_o <= '0;
			if (ctrl_strobe_i && sel_card_hit)
				sync_load_o[sel_line] <= 1'b1; // RL3
		end
	end

	// Search-sync and force-mark per line; software supplies enable with strobe
	logic [LINES-1:0] search_sync_r;
	logic [LINES-1:0] force_mark_r;
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			search_sync_r <= '0; // RL23
		else if (ctrl_strobe_i && sel_card_hit)
			search_sync_r[sel_line] <= line_control_register_i[LCR_RX_EN_BIT]; // RL8 RL16
	end
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			force_mark_r <= '0; // RL23
		else if (force_mark_cmd_i && sel_card_hit)
			force_mark_r[sel_line] <= force_mark_val_i; // RL6
	end

	// 300 ns command pulses; a new command restarts the width count
	logic [2:0] pulse_cnt_r;
	logic [1:0] pulse_line_r;
	logic pulse_is_accept_r;
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			pulse_cnt_r <= '0;
		else if ((accept_cmd_i || load_cmd_i) && sel_card_hit)
		begin
			pulse_cnt_r <= PULSE_CYC_W; // RL7
			pulse_line_r <= sel_line;
			pulse_is_accept_r <= accept_cmd_i;
		end
		else if (pulse_cnt_r != 3'h0)
			pulse_cnt_r <= pulse_cnt_r - 3'h1;
	end
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			receive_accept_pulse_o <= '0;
			holding_load_pulse_o <= '0;
		end
		else
		begin
			receive_accept_pulse_o <= '0;
			holding_load_pulse_o <= '0;
			if (pulse_cnt_r != 3'h0)
			begin
				if (pulse_is_accept_r)
					receive_accept_pulse_o[pulse_line_r] <= 1'b1; // RL7
				else
					holding_load_pulse_o[pulse_line_r] <= 1'b1; // RL7
			end
		end
	end

	// Resync request crosses to the receive clock as a toggle; the line number
	// stays put until the return toggle arrives, so a command in flight blocks another
	logic resync_tgl_r;
	logic [1:0] resync_line_r;
	logic ack_s1_r;
	logic ack_s2_r;
	logic resync_busy;
	logic resync_ack_r;
	logic [LINES-1:0] hold_off;
	assign resync_busy = resync_tgl_r ^ ack_s2_r; // RL18 RL19
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			resync_tgl_r <= 1'b0;
			resync_line_r <= 2'h0;
		end
		else if (resync_cmd_i && sel_card_hit && !resync_busy)
		begin
			resync_tgl_r <= ~resync_tgl_r; // RL6
			resync_line_r <= sel_line;
		end
	end
	// Return toggle through two flops back into the system clock
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
		end
		else
		begin
			ack_s1_r <= resync_ack_r;
			ack_s2_r <= ack_s1_r;
		end
	end

	// Link domain: reset reaches the receive clock through two flops
	logic rx_rst_s1_r;
	logic rx_rst_s2_r;
	logic rl_s1_r, rl_s2_r, rl_s3_r;
	logic [LINES-1:0] resync_set;
	logic [LINES-1:0] resync1;
	logic [LINES-1:0] resync1_set_r;
	logic [LINES-1:0] resync1_clr_r;
	logic [LINES-1:0] resync2_r;
	always_ff @(posedge rx_line_clk_i)
	begin
		rx_rst_s1_r <= reset_n_i;
		rx_rst_s2_r <= rx_rst_s1_r;
	end
	// Request toggle synchronised; third stage finds its edge
	always_ff @(posedge rx_line_clk_i)
	begin
		if (!rx_rst_s2_r)
		begin
			rl_s1_r <= 1'b0;
			rl_s2_r <= 1'b0;
			rl_s3_r <= 1'b0;
		end
		else
		begin
			rl_s1_r <= resync_tgl_r;
			rl_s2_r <= rl_s1_r;
			rl_s3_r <= rl_s2_r;
		end
	end
	// Acknowledge on the rising edge that drops the second flop
	always_ff @(posedge rx_line_clk_i)
	begin
		if (!rx_rst_s2_r)
			resync_ack_r <= 1'b0;
		else if ((|resync2_r) && !(|resync_set))
			resync_ack_r <= rl_s3_r; // RL20
	end
	genvar g;
	generate
		for (g = 0; g < LINES; g++)
		begin : g_line
			assign resync_set[g] = (rl_s2_r ^ rl_s3_r) && (resync_line_r == 2'(g)); // RL18
			assign resync1[g] = resync1_set_r[g] ^ resync1_clr_r[g]; // RL18
			assign hold_off[g] = resync_busy && (resync_line_r == 2'(g)); // RL19
			// First flop: set on the request edge, gone at the next falling edge
			always_ff @(posedge rx_line_clk_i)
			begin
				if (!rx_rst_s2_r)
					resync1_set_r[g] <= 1'b0;
				else if (resync_set[g])
					resync1_set_r[g] <= ~resync1_set_r[g]; // RL18
			end
			always_ff @(negedge rx_line_clk_i)
			begin
				if (!rx_rst_s2_r)
					resync1_clr_r[g] <= 1'b0;
				else
					resync1_clr_r[g] <= resync1_set_r[g]; // RL20
			end
			// Second flop set alongside the first, toggles back on the next rising edge
			always_ff @(posedge rx_line_clk_i)
			begin
				if (!rx_rst_s2_r)
					resync2_r[g] <= 1'b0;
				else if (resync_set[g] || resync1[g])
					resync2_r[g] <= 1'b1; // RL19
				else if (resync2_r[g])
					resync2_r[g] <= 1'b0; // RL20 RL21
			end
		end
	endgenerate
	// Hunt held off over the whole resync, wider than the flops but never missed
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			hunt_req_o <= '0;
			status_clear_o <= '0;
		end
		else
		begin
			hunt_req_o <= search_sync_r & ~hold_off; // RL18 RL19 RL17
			status_clear_o <= hold_off; // RL18
		end
	end

	// Receiver flag per line; set beats accept-clear
	logic [LINES-1:0] rx_flag_r;
	logic [LINES-1:0] flag_src;
	logic [LINES-1:0] flag_src_d_r;
	assign flag_src = single_sync_sw_i ? cr_s2_r : sm_s2_r; // RL14 RL15
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			rx_flag_r <= '0;
			flag_src_d_r <= '0;
		end
		else
		begin
			flag_src_d_r <= flag_src;
			rx_flag_r <= (rx_flag_r & ~receive_accept_pulse_o) | (flag_src & ~flag_src_d_r); // RL7 RL14 RL15
		end
	end

	// Scanned flags; master scan bit 0 selects transmit (0) or receive (1)
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			scan_flags_o <= '0;
		else if (!scan_card_hit)
			scan_flags_o <= '0;
		else if (!master_scan_i[0])
			scan_flags_o <= {ti_s2_r[scan_line], tr_s2_r[scan_line], 2'b00}; // RL4
		else
			scan_flags_o <= {2'b00, sm_s2_r[scan_line], rx_flag_r[scan_line]}; // RL4
	end

	// Receive bit window into the line control register bit 7
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			rx_bit_window_o <= 1'b0;
		else
			rx_bit_window_o <= (setup_r.mode == MODE_INT_MAINT) && sel_card_hit && rxd_s2_r[sel_line]; // RL5
	end

	// Internal baud clock: half-period divider of the system clock
	logic [15:0] baud_cnt_r;
	logic baud_clk_r;
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			baud_cnt_r <= '0;
			baud_clk_r <= 1'b0;
		end
		else if (baud_cnt_r == 16'(BAUD_DIV - 1))
		begin
			baud_cnt_r <= '0;
			baud_clk_r <= ~baud_clk_r; // RL9
		end
		else
			baud_cnt_r <= baud_cnt_r + 16'h1;
	end

	// Line clock selection; clocks are gated as data, not used as clocks here
	logic maint_clk;
	logic [LINES-1:0] tx_sel, rx_sel;
	assign maint_clk = (setup_r.mode == MODE_BAUD_MAINT) ? baud_clk_r : line_control_register_i[LCR_MAINT_CLK_BIT];
	assign tx_sel = setup_r.mode[0] ? {LINES{maint_clk}} : mtx_s2_r; // RL9 RL10
	assign rx_sel = setup_r.mode[0] ? {LINES{maint_clk}} : mrx_s2_r; // RL9 RL10
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			tx_line_clk_o <= '0;
			rx_clk_gated_o <= '0;
			scte_o <= '0;
		end
		else
		begin
			tx_line_clk_o <= tx_sel;
			rx_clk_gated_o <= rx_sel & ~(half_duplex_sw_i & cts_s2_r); // RL12
			scte_o <= (setup_r.mode == MODE_INT_MAINT) ? {LINES{line_control_register_i[LCR_MAINT_CLK_BIT]}}
				: {LINES{baud_clk_r}}; // RL11
		end
	end

	// Transmit data: force-mark holds mark (one); disable also idles at mark
	always_ff @(posedge clk_i)
	begin
		if (!reset_n_i)
			tx_data_o <= '1;
		else
			tx_data_o <= tx_data_raw_i | force_mark_r | {LINES{setup_r.tx_disable}}; // RL22
	end
endmodule // sync_line_card_control
`default_nettype wire

/* tb/sync_card_assertions.sv */
// Assertions on the ports of the sync line card control block
`timescale 1ns/1ps
`default_nettype none
module sync_card_assertions
	import sync_card_pkg::*;
#(
	parameter logic [1:0] CARD_ID = 2'h0
)
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [3:0] secondary_select_i,
	input wire logic [15:0] line_control_register_i,
	input wire logic ctrl_strobe_i,
	input wire logic resync_cmd_i,
	input wire logic accept_cmd_i,
	input wire logic [CHAR_W-1:0] sync_sw_a_i,
	input wire logic [CHAR_W-1:0] sync_sw_b_i,
	input wire logic [CHAR_W-1:0] sync_char_o,
	input wire logic [LINES-1:0] sync_load_o,
	input wire logic [LINES-1:0] receive_accept_pulse_o,
	input wire logic [LINES-1:0] hunt_req_o,
	input wire logic [LINES-1:0] status_clear_o,
	input wire logic [LINES-1:0] scte_o,
	input wire logic [LINES-1:0] tx_data_o,
	input wire logic [3:0] setup_o
);
	logic ok;
	logic [3:0] one;
	logic [15:0] l;
	// Card match and one-hot line of the secondary select
	assign ok = secondary_select_i[3:2] == CARD_ID;
	assign one = 4'h1 << secondary_select_i[1:0];
	assign l = line_control_register_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_load; ctrl_strobe_i && ok |=> sync_load_o == $past(one); endproperty
	a_load: assert property (p_load) else $error("line load missed");
	property p_char; sync_load_o != 4'h0 |-> sync_char_o == ($past(l[10]) ? $past(sync_sw_b_i) : $past(sync_sw_a_i));
	endproperty
	a_char: assert property (p_char) else $error("wrong sync char");
	property p_setup; ctrl_strobe_i && ok |=> setup_o == {$past(l[9]), $past(l[12]), $past(l[11]), $past(l[14])};
	endproperty
	a_setup: assert property (p_setup) else $error("setup not captured");
	property p_hunt; ctrl_strobe_i && ok && l[13] |-> ##2 (hunt_req_o & $past(one, 2)) != 4'h0; endproperty
	a_hunt: assert property (p_hunt) else $error("hunt not set");
	property p_accept; accept_cmd_i && ok |-> ##2 (receive_accept_pulse_o != 4'h0) [*6]; endproperty
	a_accept: assert property (p_accept) else $error("accept pulse short");
	property p_resync; resync_cmd_i && ok && hunt_req_o == one |-> ##[1:20] hunt_req_o == 4'h0; endproperty
	a_resync: assert property (p_resync) else $error("hunt kept in resync");
	property p_scte; (setup_o[2:1] == MODE_INT_MAINT && l[8]) [*4] |-> scte_o == 4'hf; endproperty
	a_scte: assert property (p_scte) else $error("terminal timing not bit 8");
	property p_mark; setup_o[3] [*3] |-> tx_data_o == 4'hf; endproperty
	a_mark: assert property (p_mark) else $error("disabled line not mark");
	property p_init; $rose(reset_n_i) |-> setup_o == 4'h0 && hunt_req_o == 4'h0; endproperty
	a_init: assert property (p_init) else $error("state after reset");
	c_load: cover property (sync_load_o != 4'h0);
	c_accept: cover property (receive_accept_pulse_o != 4'h0);
	c_clear: cover property (status_clear_o != 4'h0);
endmodule // sync_card_assertions
bind sync_line_card_control sync_card_assertions #(.CARD_ID(CARD_ID)) u_sync_card_assertions (.clk_i, .reset_n_i,
	.secondary_select_i, .line_control_register_i, .ctrl_strobe_i, .resync_cmd_i, .accept_cmd_i, .sync_sw_a_i,
	.sync_sw_b_i, .sync_char_o, .sync_load_o, .receive_accept_pulse_o, .hunt_req_o, .status_clear_o, .scte_o,
	.tx_data_o, .setup_o);
`default_nettype wire

/* tb/sync_modem_model.sv */
// Model of the four synchronous receivers and transmitters
`timescale 1ns/1ps
`default_nettype none
module sync_modem_model (
	input wire logic [3:0] hunt_req_i,
	input wire logic [3:0] status_clear_i,
	input wire logic [3:0] holding_load_pulse_i,
	output logic rx_clk_o,
	output logic [3:0] match_o,
	output logic [3:0] ready_o,
	output logic [3:0] tx_ready_o
);
	int bits [4];
	// Modem receive clock runs free; the card's link reset needs its edges
	initial
	begin
		rx_clk_o = 1'b0;
		#7;
		forever
		begin
			#15;
			rx_clk_o = ~rx_clk_o;
		end
	end
	// Bits shift on the falling edge; dropped hunt loses sync
	always @(negedge rx_clk_o)
		for (int i = 0; i < 4; i++)
			bits[i] = hunt_req_i[i] ? bits[i] + 1 : 0;
	// Match after one sync char, ready after the next
	always_comb
		for (int i = 0; i < 4; i++)
		begin
			match_o[i] = bits[i] >= 8;
			ready_o[i] = bits[i] >= 16 && !status_clear_i[i];
		end
	assign tx_ready_o = ~holding_load_pulse_i;
endmodule // sync_modem_model
`default_nettype wire

/* tb/tb.sv */
// Testbench for the sync line card control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sync_card_pkg::*;
	logic clk_i, reset_n_i, ctrl_strobe_i, resync_cmd_i, force_mark_cmd_i, force_mark_val_i, accept_cmd_i;
	logic load_cmd_i, single_sync_sw_i, rx_line_clk_i, rx_bit_window_o, s;
	logic [4:0] master_scan_i;
	logic [3:0] secondary_select_i, half_duplex_sw_i, modem_tx_clk_i, modem_rx_clk_i, rx_data_i, tx_data_raw_i;
	logic [3:0] clear_to_send_i, tx_idle_i, tx_ready_i, sync_match_flag_i, char_ready_i, scan_flags_o, sync_load_o;
	logic [3:0] receive_accept_pulse_o, holding_load_pulse_o, hunt_req_o, status_clear_o, tx_line_clk_o;
	logic [3:0] rx_clk_gated_o, scte_o, tx_data_o, setup_o;
	logic [15:0] line_control_register_i;
	logic [7:0] sync_sw_a_i, sync_sw_b_i, sync_char_o;
	int errors = 0, num_checks = 0, cyc = 0, n;
	sync_line_card_control #(.BAUD_DIV(4)) u_sync_line_card_control (.clk_i, .reset_n_i, .master_scan_i,
		.secondary_select_i, .line_control_register_i, .ctrl_strobe_i, .resync_cmd_i, .force_mark_cmd_i,
		.force_mark_val_i, .accept_cmd_i, .load_cmd_i, .sync_sw_a_i, .sync_sw_b_i, .single_sync_sw_i,
		.half_duplex_sw_i, .modem_tx_clk_i, .modem_rx_clk_i, .rx_data_i, .tx_data_raw_i, .clear_to_send_i,
		.tx_idle_i, .tx_ready_i, .sync_match_flag_i, .char_ready_i, .rx_line_clk_i, .scan_flags_o,
		.rx_bit_window_o, .sync_char_o, .sync_load_o, .receive_accept_pulse_o, .holding_load_pulse_o,
		.hunt_req_o, .status_clear_o, .tx_line_clk_o, .rx_clk_gated_o, .scte_o, .tx_data_o, .setup_o);
	sync_modem_model u_sync_modem_model (.hunt_req_i(hunt_req_o), .status_clear_i(status_clear_o),
		.holding_load_pulse_i(holding_load_pulse_o), .rx_clk_o(rx_line_clk_i), .match_o(sync_match_flag_i),
		.ready_o(char_ready_i), .tx_ready_o(tx_ready_i));
	// 20 MHz system clock
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// Cut a hang short
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	// One command cycle: kind is {strobe, resync, force, accept, load}
	task automatic put(input logic [4:0] kind, input logic [3:0] sel, input logic [15:0] line_control_register);
		@(posedge clk_i);
		secondary_select_i <= sel;
		line_control_register_i <= line_control_register;
		force_mark_val_i <= kind[2];
		{ctrl_strobe_i, resync_cmd_i, force_mark_cmd_i, accept_cmd_i, load_cmd_i} <= kind;
		@(posedge clk_i);
		{ctrl_strobe_i, resync_cmd_i, force_mark_cmd_i, accept_cmd_i, load_cmd_i} <= 5'h0;
		#1;
	endtask
	// Hunt request reaches a level in bounded time
	task automatic wait_hunt(input logic e);
		n = 0;
		while (hunt_req_o[0] !== e && n < 40)
		begin
			tick(1);
			n++;
			s |= status_clear_o[0];
		end
		chk("hunt request", 8'(e), 8'(hunt_req_o[0]));
	endtask
	initial
	begin
		{ctrl_strobe_i, resync_cmd_i, force_mark_cmd_i, force_mark_val_i, accept_cmd_i, load_cmd_i, s,
			single_sync_sw_i, master_scan_i, secondary_select_i, half_duplex_sw_i, modem_rx_clk_i,
			tx_data_raw_i, clear_to_send_i, tx_idle_i, line_control_register_i, reset_n_i} = '0;
		{modem_tx_clk_i, rx_data_i, sync_sw_a_i, sync_sw_b_i} = 24'h52963c;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		#1;
		chk("reset tx data", 8'hf, 8'(tx_data_o));
		chk("reset setup", 8'h0, 8'(setup_o));
		for (int i = 0; i < 8; i++)
		begin
			put(5'h10, {2'h0, i[1:0]}, {1'b0, i[2], 3'h0, i[0], i[1], 9'h0});
			chk("line load", 8'(4'h1 << i[1:0]), 8'(sync_load_o));
			chk("sync char", i[0] ? 8'h3c : 8'h96, sync_char_o);
			chk("setup", 8'({i[1], 2'h0, i[2]}), 8'(setup_o));
		end
		tick(3);
		chk("disabled tx", 8'hf, 8'(tx_data_o));
		put(5'h10, 4'h5, 16'h0);
		tick(1);
		chk("other card", 8'h9, {sync_load_o, setup_o});
		put(5'h10, 4'h0, 16'h0);
		put(5'h04, 4'h2, 16'h0);
		tick(4);
		chk("force mark", 8'h4, 8'(tx_data_o));
		chk("modem clock", 8'h5, 8'(tx_line_clk_o));
		@(posedge clk_i);
		{modem_rx_clk_i, half_duplex_sw_i, clear_to_send_i} <= 12'hf35;
		tick(4);
		chk("rx clock", 8'he, 8'(rx_clk_gated_o));
		put(5'h10, 4'h1, 16'h0900);
		tick(6);
		chk("maint clock", 8'hff, {tx_line_clk_o, scte_o});
		chk("bit window", 8'h1, 8'(rx_bit_window_o));
		put(5'h00, 4'h1, 16'h0800);
		tick(6);
		chk("maint clock low", 8'h0, {tx_line_clk_o, scte_o});
		put(5'h10, 4'h0, 16'h2000);
		master_scan_i <= 5'h01;
		tick(2);
		chk("hunt set", 8'h1, 8'(hunt_req_o));
		tick(40);
		chk("rx flags", 8'h3, 8'(scan_flags_o[1:0]));
		for (int k = 0; k < 2; k++)
		begin
			put(k ? 5'h01 : 5'h02, 4'h0, 16'h2000);
			n = 0;
			repeat (10)
			begin
				tick(1);
				n += k ? holding_load_pulse_o[0] : receive_accept_pulse_o[0];
			end
			chk("pulse width", 8'd6, 8'(n));
		end
		chk("flag cleared", 8'h0, 8'(scan_flags_o[0]));
		@(posedge clk_i);
		master_scan_i <= 5'h00;
		single_sync_sw_i <= 1'b1;
		tick(2);
		chk("tx flags", 8'h4, 8'(scan_flags_o));
		@(posedge clk_i);
		master_scan_i <= 5'h01;
		put(5'h08, 4'h0, 16'h2000);
		wait_hunt(1'b0);
		wait_hunt(1'b1);
		chk("status cleared", 8'h1, 8'(s));
		tick(9);
		chk("match only", 8'h2, 8'(scan_flags_o[1:0]));
		tick(6);
		chk("ready flag", 8'h3, 8'(scan_flags_o[1:0]));
		complete_run();
	end
endmodule // tb
`default_nettype wire
